// ===== hdl/flash_seq_pkg.sv
// Constants and types of the flash self-programming sequencer
package flash_seq_pkg;
   // ****************************************
   // Register map and bus answers
   // ****************************************
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_ZPTR      = 8'h04;
   localparam logic [7:0] OFF_WORD      = 8'h08;
   localparam logic [7:0] OFF_INSTR     = 8'h0C;
   localparam logic [7:0] OFF_LOADDATA  = 8'h10;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   // ****************************************
   // Control field layout and commands
   // ****************************************
   localparam int         CTRL_IE       = 7;
   localparam int         CMD_W         = 5;
   localparam logic [4:0] CMD_REENABLE  = 5'h11;
   localparam logic [4:0] CMD_LOCKSET   = 5'h09;
   localparam logic [4:0] CMD_PGWRITE   = 5'h05;
   localparam logic [4:0] CMD_PGERASE   = 5'h03;
   localparam logic [4:0] CMD_LOAD      = 5'h01;
   localparam logic [4:0] CMD_NONE      = 5'h00;
   localparam int         INSTR_STORE   = 0;
   localparam int         INSTR_LOAD    = 1;
   localparam logic [2:0] WIN_STORE     = 3'h4;
   localparam logic [2:0] WIN_LOAD_MIN  = 3'h2;

   // ****************************************
   // Addressing and read-back
   // ****************************************
   localparam int         Z_W           = 17;
   localparam int         PAGE_W        = 9;
   localparam int         PAGE_LSB      = 8;
   localparam int         WORD_W        = 16;
   localparam int         LOCK_LSB      = 2;
   localparam logic [8:0] STALL_DURING_WRITE_SECTION_FIRST    = 9'h1E0;
   localparam logic [1:0] SEL_FUSE_LOW  = 2'h0;
   localparam logic [1:0] SEL_LOCK      = 2'h1;
   localparam logic [1:0] SEL_FUSE_EXT  = 2'h2;
   localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
   localparam logic [1:0] LOCK_UNUSED   = 2'h3;
   localparam logic [5:0] EXT_UNUSED    = 6'h3F;
   localparam logic [3:0] BOOT_LOCK_RST = 4'hF;
   localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

   // ****************************************
   // Timing
   // ****************************************
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         PROG_TIME_US  = 3700; // 3.7 ms least programming time
   localparam int         PROG_CYCLES   =
      (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         TIMER_W       = 20;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      OP_IDLE  = 2'b00,
      OP_ERASE = 2'b01,
      OP_WRITE = 2'b11,
      OP_LOCK  = 2'b10
   } prog_op_t;

   typedef struct packed {
      logic              active;
      logic              erase;
      logic              write;
      logic              lockProg;
      logic [PAGE_W-1:0] page;
   } flash_op_t;

   typedef struct packed {
      logic [7:0] low;
      logic [7:0] high;
      logic [7:0] ext;
      logic [1:0] memLock;
   } fuse_t;
endpackage

// ===== hdl/flash_self_program_sequencer.sv
// Flash self-programming sequencer with AXI4-Lite register access
//
// Notes on behaviour
// R1 - Erase pattern plus store in four cycles
// R2 - Erase halts core only in stall section
// R3 - Software zeroes non-page Z bits
// R4 - Load pattern plus store buffers R1:R0 word
// R5 - Buffer clears: page write, reenable, reset
// R6 - Software writes each buffer word once
// R7 - EEPROM write during load discards buffer
// R8 - Write pattern plus store writes buffer
// R9 - Page write halts core only in stall section
// R10 - Interrupt level while enable bit reads zero
// R11 - Readable section blocked, busy flag held
// R12 - Software reenables section before reading it
// R13 - Lock pattern programs boot locks from R0
// R14 - Lock programming never halts or blocks
// R15 - Software advised Z one, R0 spare ones
// R16 - EEPROM busy blocks programming and read-back
// R17 - Load within three cycles returns lock byte
// R18 - Lock-set and enable bits self-clear
// R19 - Lock byte: boot 5..2, memory 1..0
// R20 - Z selects low, high, extended fuse byte
// R21 - Programmed reads zero, unprogrammed one
// R22 - Flash write survives system reset
// R23 - Undefined command patterns are ignored
// R24 - Busy flag: set on start, cleared by load
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_sequencer #(
   parameter int PROG_CYCLES = flash_seq_pkg::PROG_CYCLES,
   parameter int WORD_SEL_W  = 7
) (
   // Clock and resets
   input  wire logic                       clk_sys,
   input  wire logic                       nrst,
   input  wire logic                       nrstPower,
   // AXI4-Lite write address and data
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [flash_seq_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       wvalid,
   output logic                            wready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   // AXI4-Lite write response
   output logic                            bvalid,
   input  wire logic                       bready,
   output logic [1:0]                      bresp,
   // AXI4-Lite read
   input  wire logic                       arvalid,
   output logic                            arready,
   input  wire logic [flash_seq_pkg::ADDR_W-1:0] araddr,
   output logic                            rvalid,
   input  wire logic                       rready,
   output logic [31:0]                     rdata,
   output logic [1:0]                      rresp,
   // Neighbours: EEPROM and fuse cells
   input  wire logic                       eepromWriteBusy,
   input  wire flash_seq_pkg::fuse_t       fuses,
   // Flash array side
   output flash_seq_pkg::flash_op_t        flashOp,
   input  wire logic [WORD_SEL_W-1:0]      bufAddr,
   output logic [flash_seq_pkg::WORD_W-1:0] bufData,
   // Core side
   output logic                            cpuHalt,
   output logic                            rwwReadBlock,
   output logic                            selfProgIrq,
   output logic [7:0]                      loadData,
   output logic                            loadDone
);
   import flash_seq_pkg::*;

   localparam int PAGE_WORDS = 2 ** WORD_SEL_W;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic                   awGot;
      logic [ADDR_W-1:0]      awAddr;
      logic                   wGot;
      logic [31:0]            wData;
      logic [3:0]             wStrb;
      logic                   bValid;
      logic [1:0]             bResp;
      logic                   rValid;
      logic [31:0]            rData;
      logic [1:0]             rResp;
      logic                   ie;
      logic [CMD_W-1:0]       cmd;
      logic [2:0]             win;
      logic                   busyFlag;
      logic [Z_W-1:0]         zPtr;
      logic [WORD_W-1:0]      word;
      logic [7:0]             loadData;
      logic                   loadDone;
      logic [WORD_W-1:0]      bufOut;
      logic [PAGE_WORDS-1:0][WORD_W-1:0] buffer;
   } sys_t;

   // Engine state lives on the power-on reset only
   typedef struct packed {
      prog_op_t               op;
      logic [TIMER_W-1:0]     timer;
      logic [PAGE_W-1:0]      page;
      logic [3:0]             bootLock;
   } prog_t;

   sys_t              s;
   sys_t              next_s;
   prog_t             p;
   prog_t             next_p;
   prog_op_t          startOp;
   logic [PAGE_W-1:0] startPage;
   logic              progBusy;
   logic              progDone;
   logic              pageOp;
   logic [CMD_W-1:0]  cmdView;
   logic              enBit;

   // ****************************************
   // Helpers
   // ****************************************
   // Merge write data into a register by byte lanes
   function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // Address decode shared by reads and writes
   function automatic logic regHit(input logic [ADDR_W-1:0] a);
      return (a == OFF_CTRL) || (a == OFF_ZPTR) || (a == OFF_WORD) ||
             (a == OFF_INSTR) || (a == OFF_LOADDATA);
   endfunction

   // Defined command patterns only
   function automatic logic cmdLegal(input logic [CMD_W-1:0] c);
      return (c == CMD_REENABLE) || (c == CMD_LOCKSET) || (c == CMD_PGWRITE) ||
             (c == CMD_PGERASE) || (c == CMD_LOAD);
   endfunction

   // ****************************************
   // Status view
   // ****************************************
   // Engine busy keeps the command bits and enable bit showing high
   assign progBusy = (p.op != OP_IDLE);
   assign progDone = progBusy && (p.timer == TIMER_W'(1));
   assign pageOp   = (p.op == OP_ERASE) || (p.op == OP_WRITE);

   always_comb
   begin
      case (p.op)
         OP_ERASE: cmdView = CMD_PGERASE;
         OP_WRITE: cmdView = CMD_PGWRITE;
         OP_LOCK:  cmdView = CMD_LOCKSET;
         default:  cmdView = s.cmd;
      endcase
   end

   assign enBit = cmdView[0];

   // ****************************************
   // System-domain next state
   // ****************************************
   always_comb
   begin
      logic [31:0] wv;
      logic        storeReq;
      logic        loadReq;
      logic [CMD_W-1:0] newCmd;
      wv        = 32'h0000_0000;
      storeReq  = 1'b0;
      loadReq   = 1'b0;
      newCmd    = CMD_NONE;
      next_s    = s;
      startOp   = OP_IDLE;
      startPage = s.zPtr[PAGE_LSB +: PAGE_W]; // R3
      next_s.loadDone = 1'b0;
      next_s.bufOut   = s.buffer[bufAddr];
      // Arming window runs down; unused command falls away
      if (s.win != 3'h0)
      begin
         next_s.win = s.win - 3'h1;
         if (s.win == 3'h1)
            next_s.cmd = CMD_NONE; // R18
      end
      // Bus write channels, either order
      if (awvalid && awready)
      begin
         next_s.awGot  = 1'b1;
         next_s.awAddr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_s.wGot  = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
      end
      // Register write once both halves are in
      if (s.awGot && s.wGot)
      begin
         next_s.awGot  = 1'b0;
         next_s.wGot   = 1'b0;
         next_s.bValid = 1'b1;
         next_s.bResp  = regHit(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
         wv = laneMerge(32'h0000_0000, s.wData, s.wStrb);
         case (s.awAddr)
            OFF_CTRL:
            begin
               if (s.wStrb[0])
               begin
                  next_s.ie = wv[CTRL_IE];
                  newCmd = wv[CMD_W-1:0];
                  // Re-arming is refused while the engine runs
                  if (cmdLegal(newCmd) && !progBusy) // R23
                  begin
                     next_s.cmd = newCmd;
                     next_s.win = WIN_STORE;
                     if (newCmd == CMD_REENABLE)
                        next_s.buffer = '{default: ERASED_WORD}; // R5
                  end
               end
            end
            OFF_ZPTR:  next_s.zPtr = Z_W'(laneMerge({15'h0000, s.zPtr}, s.wData, s.wStrb));
            OFF_WORD:  next_s.word = WORD_W'(laneMerge({16'h0000, s.word}, s.wData, s.wStrb));
            OFF_INSTR:
            begin
               storeReq = s.wStrb[0] && wv[INSTR_STORE];
               loadReq  = s.wStrb[0] && wv[INSTR_LOAD];
            end
            default:   newCmd = CMD_NONE;
         endcase
      end
      if (s.bValid && bready)
         next_s.bValid = 1'b0;
      // Store-program instruction inside the window
      if (storeReq && (s.win != 3'h0) && !eepromWriteBusy && !progBusy) // R16
      begin
         next_s.cmd = CMD_NONE;
         next_s.win = 3'h0;
         case (s.cmd)
            CMD_LOAD:
            begin
               next_s.buffer[s.zPtr[1 +: WORD_SEL_W]] = s.word; // R4
               next_s.busyFlag = 1'b0; // R24
            end
            CMD_PGERASE:
            begin
               startOp = OP_ERASE; // R1
               next_s.busyFlag = 1'b1; // R24
            end
            CMD_PGWRITE:
            begin
               startOp = OP_WRITE; // R8
               next_s.busyFlag = 1'b1; // R24
            end
            CMD_LOCKSET:  startOp = OP_LOCK; // R13
            CMD_REENABLE: next_s.busyFlag = 1'b0;
            default:      startOp = OP_IDLE;
         endcase
      end
      // Load-program instruction: fuse and lock read-back
      if (loadReq && (s.cmd == CMD_LOCKSET) && (s.win >= WIN_LOAD_MIN) &&
          !eepromWriteBusy) // R16
      begin
         next_s.cmd      = CMD_NONE; // R18
         next_s.win      = 3'h0;
         next_s.loadDone = 1'b1;
         case (s.zPtr[1:0]) // R20
            SEL_FUSE_LOW:  next_s.loadData = fuses.low;
            SEL_LOCK:      next_s.loadData = {LOCK_UNUSED, p.bootLock,
                                              fuses.memLock}; // R19 R17
            SEL_FUSE_EXT:  next_s.loadData = {EXT_UNUSED, fuses.ext[1:0]};
            SEL_FUSE_HIGH: next_s.loadData = fuses.high;
            default:       next_s.loadData = fuses.low;
         endcase
      end
      // EEPROM write in the middle of page loading
      if (eepromWriteBusy && (s.cmd == CMD_LOAD))
      begin
         next_s.buffer = '{default: ERASED_WORD}; // R7
         next_s.cmd    = CMD_NONE;
         next_s.win    = 3'h0;
      end
      // Written page leaves an empty buffer behind
      if (progDone && (p.op == OP_WRITE))
         next_s.buffer = '{default: ERASED_WORD}; // R5
      // Bus read, answered the cycle after the address
      if (arvalid && arready)
      begin
         next_s.rValid = 1'b1;
         next_s.rResp  = regHit(araddr) ? RESP_OKAY : RESP_SLVERR;
         case (araddr)
            OFF_CTRL:     next_s.rData = {24'h000000, s.ie,
                                          s.busyFlag || pageOp, 1'b0, cmdView}; // R11
            OFF_ZPTR:     next_s.rData = {15'h0000, s.zPtr};
            OFF_WORD:     next_s.rData = {16'h0000, s.word};
            OFF_LOADDATA: next_s.rData = {24'h000000, s.loadData};
            default:      next_s.rData = 32'h0000_0000;
         endcase
      end
      else if (s.rValid && rready)
         next_s.rValid = 1'b0;
   end

   // ****************************************
   // Programming engine next state
   // ****************************************
   always_comb
   begin
      next_p = p;
      if (progBusy)
      begin
         next_p.timer = p.timer - TIMER_W'(1);
         if (progDone)
            next_p.op = OP_IDLE;
      end
      if (startOp != OP_IDLE)
      begin
         next_p.op    = startOp;
         next_p.timer = TIMER_W'(PROG_CYCLES);
         next_p.page  = startPage;
         // Zero in R0 programs the lock; programmed stays zero
         if (startOp == OP_LOCK)
            next_p.bootLock = p.bootLock & s.word[LOCK_LSB +: 4]; // R13 R21
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // System reset clears control, bus and buffer
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         s        <= '0;
         s.buffer <= '{default: ERASED_WORD}; // R5
      end
      else
         s <= next_s;
   end

   // A system reset must not cut a running flash write short
   always_ff @(posedge clk_sys or negedge nrstPower)
   begin
      if (!nrstPower)
      begin
         p          <= '0;
         p.bootLock <= BOOT_LOCK_RST;
      end
      else
         p <= next_p; // R22
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Bus handshakes; one write and one read under way
   assign awready = !s.awGot && !s.bValid;
   assign wready  = !s.wGot && !s.bValid;
   assign bvalid  = s.bValid;
   assign bresp   = s.bResp;
   assign arready = !s.rValid;
   assign rvalid  = s.rValid;
   assign rdata   = s.rData;
   assign rresp   = s.rResp;

   // Flash array command, held for the whole operation
   assign flashOp.active   = progBusy;
   assign flashOp.erase    = (p.op == OP_ERASE);
   assign flashOp.write    = (p.op == OP_WRITE);
   assign flashOp.lockProg = (p.op == OP_LOCK);
   assign flashOp.page     = p.page;
   assign bufData          = s.bufOut;

   // Stall section pages halt the core; lock programming never does
   assign cpuHalt      = pageOp && (p.page >= STALL_DURING_WRITE_SECTION_FIRST); // R2 R9 R14
   assign rwwReadBlock = s.busyFlag || pageOp; // R11
   assign selfProgIrq  = s.ie && !enBit; // R10
   assign loadData     = s.loadData;
   assign loadDone     = s.loadDone;
endmodule

`default_nettype wire

// ===== tb/flash_neighbour_model.sv
// EEPROM and fuse-cell neighbour model for the flash sequencer bench
`timescale 1ns/1ps
`default_nettype none

module flash_neighbour_model
   import flash_seq_pkg::*;
#(
   parameter logic [7:0] FUSE_LOW  = 8'hA5,
   parameter logic [7:0] FUSE_HIGH = 8'h3C,
   parameter logic [7:0] FUSE_EXT  = 8'hFE,
   parameter logic [1:0] MEM_LOCK  = 2'h2,
   parameter int         EE_CYCLES = 60
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic nrst,
   // EEPROM write request and status
   input  wire logic eeStart,
   output logic      eepromWriteBusy,
   // Fuse cells, zero means programmed
   output fuse_t     fuses
);
   int eeLeft;

   // Fuse cells are static levels
   assign fuses = '{low: FUSE_LOW, high: FUSE_HIGH, ext: FUSE_EXT, memLock: MEM_LOCK};

   // EEPROM busy lasts a fixed span after each start
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         eeLeft <= 0;
      else if (eeStart)
         eeLeft <= EE_CYCLES;
      else if (eeLeft > 0)
         eeLeft <= eeLeft - 1;
   end
   assign eepromWriteBusy = (eeLeft > 0);
endmodule

`default_nettype wire

// ===== tb/flash_seq_checker.sv
// Concurrent checks on the flash sequencer ports
`timescale 1ns/1ps
`default_nettype none

module flash_seq_checker
   import flash_seq_pkg::*;
#(
   parameter int PROG_CYCLES = 20
) (
   // Clock and resets
   input wire logic      clk_sys,
   input wire logic      nrst,
   input wire logic      nrstPower,
   // Bus handshakes
   input wire logic      awvalid,
   input wire logic      awready,
   input wire logic      wvalid,
   input wire logic      wready,
   input wire logic      bvalid,
   input wire logic      arvalid,
   input wire logic      arready,
   input wire logic      rvalid,
   // Flash and core side
   input wire flash_op_t flashOp,
   input wire logic      cpuHalt,
   input wire logic      rwwReadBlock,
   input wire logic      selfProgIrq,
   input wire logic      loadDone
);
   int opCnt;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst || !nrstPower);

   // Length of the running operation; only power reset may cut it short
   always_ff @(posedge clk_sys or negedge nrstPower)
   begin
      if (!nrstPower)
         opCnt <= 0;
      else
         opCnt <= flashOp.active ? opCnt + 1 : 0;
   end

   property p_opLen;
      $fell(flashOp.active) |-> opCnt == PROG_CYCLES;
   endproperty
   a_opLen: assert property (p_opLen) else $error("operation length wrong");

   property p_haltStall;
      flashOp.active && (flashOp.erase || flashOp.write) && flashOp.page >= STALL_DURING_WRITE_SECTION_FIRST
         |-> cpuHalt;
   endproperty
   a_haltStall: assert property (p_haltStall) else $error("core not halted");

   property p_noHaltRww;
      flashOp.active && flashOp.page < STALL_DURING_WRITE_SECTION_FIRST && !flashOp.lockProg |-> !cpuHalt;
   endproperty
   a_noHaltRww: assert property (p_noHaltRww) else $error("core halted needlessly");

   property p_lockFree;
      flashOp.lockProg |-> !cpuHalt;
   endproperty
   a_lockFree: assert property (p_lockFree) else $error("halt during lock set");

   property p_block;
      flashOp.active && (flashOp.erase || flashOp.write) |-> rwwReadBlock;
   endproperty
   a_block: assert property (p_block) else $error("section not blocked");

   property p_irqQuiet;
      flashOp.active |-> !selfProgIrq;
   endproperty
   a_irqQuiet: assert property (p_irqQuiet) else $error("irq while enable set");

   property p_bAnswer;
      awvalid && awready && wvalid && wready |-> ##[1:2] bvalid;
   endproperty
   a_bAnswer: assert property (p_bAnswer) else $error("no write response");

   property p_rAnswer;
      arvalid && arready |=> rvalid;
   endproperty
   a_rAnswer: assert property (p_rAnswer) else $error("no read data");

   property p_loadPulse;
      loadDone |=> !loadDone;
   endproperty
   a_loadPulse: assert property (p_loadPulse) else $error("load done too long");

   // Main scenarios reached
   c_halt: cover property (flashOp.active && cpuHalt);
   c_lock: cover property (flashOp.lockProg);
   c_load: cover property (loadDone);
endmodule

bind flash_self_program_sequencer flash_seq_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
   .clk_sys, .nrst, .nrstPower, .awvalid, .awready, .wvalid, .wready, .bvalid,
   .arvalid, .arready, .rvalid, .flashOp, .cpuHalt, .rwwReadBlock, .selfProgIrq,
   .loadDone);

`default_nettype wire

// ===== tb/tb_flash_self_program_sequencer.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_flash_self_program_sequencer;
   import flash_seq_pkg::*;
   logic clk_sys = 0, nrst = 0, nrstPower = 0, eeStart = 0, eepromWriteBusy;
   logic awvalid = 0, awready, wvalid = 0, wready, bvalid, arvalid = 0, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, loadData;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [1:0] bresp, rresp;
   logic [6:0] bufAddr = 7'h00;
   logic [15:0] bufData;
   logic cpuHalt, rwwReadBlock, selfProgIrq, loadDone;
   fuse_t fuses;
   flash_op_t flashOp;
   int fail_count = 0, checked = 0;
   typedef struct {logic [16:0] z; logic [7:0] e;} row_t;
   row_t rows [4];

   always #5 clk_sys = ~clk_sys;

   flash_neighbour_model nb_u (.clk_sys(clk_sys), .nrst(nrst), .eeStart(eeStart),
      .eepromWriteBusy(eepromWriteBusy), .fuses(fuses));
   flash_self_program_sequencer #(.PROG_CYCLES(20)) dut_u (.clk_sys(clk_sys), .nrst(nrst),
      .nrstPower(nrstPower), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
      .bready(1'b1), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(1'b1), .rdata(rdata), .rresp(rresp),
      .eepromWriteBusy(eepromWriteBusy), .fuses(fuses), .flashOp(flashOp),
      .bufAddr(bufAddr), .bufData(bufData), .cpuHalt(cpuHalt), .rwwReadBlock(rwwReadBlock),
      .selfProgIrq(selfProgIrq), .loadData(loadData), .loadDone(loadDone));

   // Compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // Bus write; called just after a rising edge, returns on one
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      int n = 0;
      logic aT, wT, got = 0;
      awvalid <= 1; wvalid <= 1; awaddr <= a; wdata <= d;
      while (!got && n < 50)
      begin
         @(negedge clk_sys);
         n++;
         aT = awvalid && awready;
         wT = wvalid && wready;
         if (bvalid === 1'b1)
         begin
            got = 1;
            chk(bresp, er);
         end
         @(posedge clk_sys);
         if (aT) awvalid <= 0;
         if (wT) wvalid <= 0;
      end
      if (!got) chk(0, 1);
   endtask

   // Bus read and compare
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
      int n = 0;
      logic aT, got = 0;
      arvalid <= 1; araddr <= a;
      while (!got && n < 50)
      begin
         @(negedge clk_sys);
         n++;
         aT = arvalid && arready;
         if (rvalid === 1'b1)
         begin
            got = 1;
            chk(rdata, e);
            chk(rresp, er);
         end
         @(posedge clk_sys);
         if (aT) arvalid <= 0;
      end
      if (!got) chk(0, 1);
   endtask

   // Arm a command, then issue the instruction at once
   task automatic cmd(input logic [7:0] c, input logic [1:0] instr);
      wr(OFF_CTRL, {24'h0, c});
      wr(OFF_INSTR, {30'h0, instr});
   endtask

   // Wait for the flash operation to finish, bounded
   task automatic waitIdle();
      int n = 0;
      while (flashOp.active !== 1'b0 && n < 100)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk(flashOp.active, 0);
      @(posedge clk_sys);
   endtask

   // Buffer word seen by the flash array side
   task automatic bufChk(input logic [6:0] a, input logic [15:0] e);
      bufAddr <= a;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(bufData, e);
      @(posedge clk_sys);
   endtask

   task automatic wrap_up();
      if (fail_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      #100us;
      fail_count++;
      wrap_up();
   end

   initial
   begin
      rows[0] = '{17'h0, 8'hA5};
      rows[1] = '{17'h1, {2'h3, BOOT_LOCK_RST, 2'h2}};
      rows[2] = '{17'h2, {EXT_UNUSED, 2'h2}};
      rows[3] = '{17'h3, 8'h3C};
      repeat (2) @(posedge clk_sys);
      nrst <= 1; nrstPower <= 1;
      @(posedge clk_sys);
      // Read-back table
      foreach (rows[i])
      begin
         wr(OFF_ZPTR, {15'h0, rows[i].z});
         cmd(8'h09, 2'h2);
         chk(loadData, rows[i].e);
         rd(OFF_LOADDATA, {24'h0, rows[i].e});
      end
      rd(OFF_CTRL, 32'h0);
      rd(8'h40, 32'h0, RESP_SLVERR);
      wr(8'h44, 32'h1, RESP_SLVERR);
      bufChk(7'h0, ERASED_WORD);
      // Page load then page write to the stall section, irq enabled
      wr(OFF_ZPTR, 32'h6);
      wr(OFF_WORD, 32'h1234);
      cmd(8'h01, 2'h1);
      bufChk(7'h3, 16'h1234);
      wr(OFF_ZPTR, {15'h0, STALL_DURING_WRITE_SECTION_FIRST, 8'h0});
      cmd(8'h85, 2'h1);
      @(negedge clk_sys);
      chk({flashOp.write, cpuHalt, flashOp.page}, {2'b11, STALL_DURING_WRITE_SECTION_FIRST});
      @(posedge clk_sys);
      rd(OFF_CTRL, 32'hC5);
      waitIdle();
      bufChk(7'h3, ERASED_WORD);
      chk({selfProgIrq, rwwReadBlock}, 2'b11);
      cmd(8'h11, 2'h1);
      rd(OFF_CTRL, 32'h0);
      chk({selfProgIrq, rwwReadBlock}, 2'b00);
      // Erase in readable section survives a system reset
      wr(OFF_ZPTR, 32'h500);
      cmd(8'h03, 2'h1);
      @(negedge clk_sys);
      chk({flashOp.erase, cpuHalt, rwwReadBlock, flashOp.page}, {3'b101, 9'h5});
      nrst <= 0;
      @(negedge clk_sys);
      nrst <= 1;
      @(negedge clk_sys);
      chk(flashOp.active, 1);
      @(posedge clk_sys);
      waitIdle();
      // Missed window and undefined pattern do nothing
      wr(OFF_CTRL, 32'h03);
      repeat (6) @(posedge clk_sys);
      wr(OFF_INSTR, 32'h1);
      chk(flashOp.active, 0);
      cmd(8'h07, 2'h1);
      chk(flashOp.active, 0);
      rd(OFF_CTRL, 32'h0);
      // EEPROM write discards the buffer and blocks lock read-back and page erase
      wr(OFF_ZPTR, 32'h8);
      wr(OFF_WORD, 32'hBEEF);
      cmd(8'h01, 2'h1);
      bufChk(7'h4, 16'hBEEF);
      eeStart <= 1;
      @(posedge clk_sys);
      eeStart <= 0;
      wr(OFF_CTRL, 32'h01);
      bufChk(7'h4, ERASED_WORD);
      wr(OFF_ZPTR, 32'h0);
      cmd(8'h09, 2'h2);
      rd(OFF_LOADDATA, 32'h0);
      wr(OFF_ZPTR, 32'h500);
      cmd(8'h03, 2'h1);
      chk(flashOp.active, 0);
      while (eepromWriteBusy === 1'b1) @(posedge clk_sys);
      // Boot lock programming, spare bits one
      wr(OFF_ZPTR, 32'h1);
      wr(OFF_WORD, 32'hF3);
      cmd(8'h09, 2'h1);
      @(negedge clk_sys);
      chk({flashOp.lockProg, cpuHalt}, 2'b10);
      @(posedge clk_sys);
      waitIdle();
      cmd(8'h09, 2'h2);
      rd(OFF_LOADDATA, {24'h0, 2'h3, 4'hC, 2'h2});
      wrap_up();
   end
endmodule

`default_nettype wire
